// file: src/mft_edge.sv
// Edge detector with selectable polarity for one timer pin.
`timescale 1ns/10ps
`default_nettype none
module mft_edge (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_pin,
	input wire logic i_rising,
	output logic o_event
);
	// Previous sample of the pin.
	logic prev_reg;

	// ------------------------------------------------------------
	// Pin history
	// ------------------------------------------------------------
	// The pin is taken as synchronous, so one register suffices.
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			prev_reg <= 1'b0;
		else
			prev_reg <= i_pin;
	end

	// Pulse on the selected transition.
	assign o_event = i_rising ? (i_pin & ~prev_reg) : (~i_pin & prev_reg);
endmodule : mft_edge
`default_nettype wire

// file: src/mft_pkg.sv
// Package with register map, field positions and encodings of the multifunction timer.
package mft_pkg;
	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_MODE_CONTROL = 8'h00; // Mode control register.
	localparam logic [7:0] OFS_CLOCK_SEL = 8'h04; // Counter clock selectors and prescaler.
	localparam logic [7:0] OFS_FIRST_CNT = 8'h08; // First counter.
	localparam logic [7:0] OFS_SECOND_CNT = 8'h0c; // Second counter.
	localparam logic [7:0] OFS_RELOAD_A = 8'h10; // Reload/capture A.
	localparam logic [7:0] OFS_RELOAD_B = 8'h14; // Reload/capture B.
	localparam logic [7:0] OFS_PENDING = 8'h18; // Pending flags, write one to clear.
	localparam logic [7:0] OFS_IRQ_EN = 8'h1c; // Interrupt enables A to D.
	localparam logic [7:0] OFS_SW_TRIG = 8'h20; // Software trigger strobe.
	// ------------------------------------------------------------
	// Mode control field positions
	// ------------------------------------------------------------
	localparam int MC_MODE_LO = 0; // Mode select field, two bits.
	localparam int MC_PT_EN = 2; // Pulse-train enable.
	localparam int MC_OUT_LVL = 3; // PWM initial level.
	localparam int MC_PIN_A_EN = 4; // Pin A function enable.
	localparam int MC_PIN_B_EN = 5; // Pin B function enable.
	localparam int MC_EDGE_A = 6; // Pin A edge, one for rising.
	localparam int MC_EDGE_B = 7; // Pin B edge, one for rising.
	localparam int MC_TRIG_SRC = 8; // Train trigger source, zero for pin B.
	localparam int MC_TIMER_EN = 9; // Timer enable.
	localparam int MC_WIDTH = 10; // Implemented mode control bits.
	// ------------------------------------------------------------
	// Encodings and reset values
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_PWM = 2'h0; // PWM and system timer.
	localparam logic [1:0] MODE_CAPTURE = 2'h1; // Dual-input capture.
	localparam logic [2:0] CK_NONE = 3'h0; // No clock.
	localparam logic [2:0] CK_SYSTEM = 3'h1; // Prescaled system clock.
	localparam logic [2:0] CK_EXT_EVENT = 3'h2; // Pin B edges.
	localparam logic [2:0] CK_PULSE_ACC = 3'h3; // Prescaled system clock while pin B high.
	localparam logic [15:0] CNT_ALL_ONES = 16'hffff; // Capture preset value.
	localparam logic [15:0] CNT_ZERO = 16'h0000; // Pulse-train second counter preset.
	localparam logic [31:0] RESET_WORD = 32'h0000_0000; // Reset value of all registers.
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000; // Answer at unmapped offsets.
	// ------------------------------------------------------------
	// Bus encodings
	// ------------------------------------------------------------
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2; // NONSEQ transfer.
	localparam logic [1:0] HTRANS_SEQ = 2'h3; // SEQ transfer.
endpackage : mft_pkg

// file: src/mft_timer.sv
// Dual 16-bit down-counting timer with PWM, pulse-train and capture modes, AHB-Lite slave.
//
// Behaviour
// (RULE1) PWM first counter starts from preloaded value.
// (RULE2) Underflow reloads alternately from A then B.
// (RULE3) Restart always takes first reload from A.
// (RULE4) Pin A toggles on each first-counter underflow.
// (RULE5) Output-level bit sets initial PWM level.
// (RULE6) Reload A/B sets pending flag A/B.
// (RULE7) Second counter counts, underflow flag under D.
// (RULE8) Pulse train is PWM mode plus enable.
// (RULE9) Train underflow toggles and decrements second counter.
// (RULE10) Second underflow at train end stops first clock.
// (RULE11) Train second-counter underflow presets to zero.
// (RULE12) Software rewrites second counter before next train.
// (RULE13) Pulses equal second counter value plus one.
// (RULE14) Train starts on pin B edge or software.
// (RULE15) Software trigger only after timer enable set.
// (RULE16) Disabled at reset; train starts reload from A.
// (RULE17) Capture copies first counter into A or B.
// (RULE18) Edge select per pin, rising or falling.
// (RULE19) Preset enable: capture then preset all ones.
// (RULE20) Capture pulses last at least one clock.
// (RULE21) Capture A, B, underflow set own flags.
// (RULE22) Capture mode: event clocking stops first counter.
// (RULE23) Counters tick by one, hold on no-clock.
//
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module mft_timer #(
	parameter int CNT_W = 16
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	input wire logic i_pin_a,
	input wire logic i_pin_b,
	output logic o_pin_a,
	output logic o_pin_a_oe_b,
	output logic o_irq_a,
	output logic o_irq_b,
	output logic o_irq_c,
	output logic o_irq_d
);
	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic [1:0] rst_sync_reg; // Two-stage reset release.
	logic rst_b; // Released reset used by all logic.

	// Release the reset through two flip-flops.
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			rst_sync_reg <= 2'b00;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_b = rst_sync_reg[1];

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [mft_pkg::MC_WIDTH-1:0] mode_control_reg; // Mode control.
	logic [15:0] clock_sel_reg; // [2:0] first, [5:3] second selector, [15:8] prescale.
	logic [CNT_W-1:0] first_counter_reg; // First counter.
	logic [CNT_W-1:0] second_counter_reg; // Second counter.
	logic [CNT_W-1:0] reload_capture_a_reg; // Reload/capture A.
	logic [CNT_W-1:0] reload_capture_b_reg; // Reload/capture B.
	logic [3:0] pending_reg; // Pending flags A, B, C, D in bits 0 to 3.
	logic [3:0] irq_enable_reg; // Interrupt enables A to D.
	logic next_from_b_reg; // Next reload comes from B.
	logic pin_a_out_reg; // PWM output level.
	logic train_run_reg; // Pulse train running.
	logic [7:0] prescale_cnt_reg; // Prescaler counter.

	// Decoded fields.
	logic [1:0] mode_select_field;
	logic pulse_train_enable, pwm_initial_level_bit, pin_a_function_enable, pin_b_function_enable;
	logic edge_select_a, edge_select_b, train_trigger_source, timer_enable_bit;
	logic [2:0] ck_first, ck_second;
	assign mode_select_field = mode_control_reg[mft_pkg::MC_MODE_LO +: 2];
	assign pulse_train_enable = mode_control_reg[mft_pkg::MC_PT_EN];
	assign pwm_initial_level_bit = mode_control_reg[mft_pkg::MC_OUT_LVL];
	assign pin_a_function_enable = mode_control_reg[mft_pkg::MC_PIN_A_EN];
	assign pin_b_function_enable = mode_control_reg[mft_pkg::MC_PIN_B_EN];
	assign edge_select_a = mode_control_reg[mft_pkg::MC_EDGE_A];
	assign edge_select_b = mode_control_reg[mft_pkg::MC_EDGE_B];
	assign train_trigger_source = mode_control_reg[mft_pkg::MC_TRIG_SRC];
	assign timer_enable_bit = mode_control_reg[mft_pkg::MC_TIMER_EN];
	assign ck_first = clock_sel_reg[2:0];
	assign ck_second = clock_sel_reg[5:3];

	// Mode decode.
	logic is_pwm, is_train, is_cap;
	assign is_pwm = timer_enable_bit && mode_select_field == mft_pkg::MODE_PWM; // [RULE8]
	assign is_train = is_pwm && pulse_train_enable; // [RULE8]
	assign is_cap = timer_enable_bit && mode_select_field == mft_pkg::MODE_CAPTURE;

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	logic ap_valid; // Address phase accepted this cycle.
	logic dp_write_reg; // Data phase is a write.
	logic dp_read_reg; // Data phase is a read.
	logic [7:0] dp_addr_reg; // Byte offset of the data phase.
	logic wr; // Write strobe with data.
	logic [7:0] wa; // Write offset.
	logic sw_trig; // Software trigger pulse.
	assign ap_valid = i_hsel && i_hready && (i_htrans == mft_pkg::HTRANS_NONSEQ || i_htrans == mft_pkg::HTRANS_SEQ);
	assign o_hreadyout = 1'b1; // Zero wait states.
	assign o_hresp = 1'b0; // Always OKAY.
	assign wr = dp_write_reg;
	assign wa = dp_addr_reg;
	assign sw_trig = wr && wa == mft_pkg::OFS_SW_TRIG && i_hwdata[0];

	// Capture the address phase.
	always_ff @(posedge i_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dp_write_reg <= 1'b0;
			dp_read_reg <= 1'b0;
			dp_addr_reg <= 8'h00;
		end
		else
		begin
			dp_write_reg <= ap_valid && i_hwrite;
			dp_read_reg <= ap_valid && !i_hwrite;
			if (ap_valid)
				dp_addr_reg <= i_haddr[7:0];
		end
	end

	// Read data is registered in the address phase so it stands in the data phase.
	always_ff @(posedge i_clk or negedge rst_b)
	begin
		if (!rst_b)
			o_hrdata <= mft_pkg::RESET_WORD;
		else if (ap_valid && !i_hwrite)
		begin
			case (i_haddr[7:0])
				mft_pkg::OFS_MODE_CONTROL: o_hrdata <= 32'(mode_control_reg);
				mft_pkg::OFS_CLOCK_SEL: o_hrdata <= 32'(clock_sel_reg);
				mft_pkg::OFS_FIRST_CNT: o_hrdata <= 32'(first_counter_reg);
				mft_pkg::OFS_SECOND_CNT: o_hrdata <= 32'(second_counter_reg);
				mft_pkg::OFS_RELOAD_A: o_hrdata <= 32'(reload_capture_a_reg);
				mft_pkg::OFS_RELOAD_B: o_hrdata <= 32'(reload_capture_b_reg);
				mft_pkg::OFS_PENDING: o_hrdata <= 32'({train_run_reg, pin_a_out_reg, 2'b00, pending_reg});
				mft_pkg::OFS_IRQ_EN: o_hrdata <= 32'(irq_enable_reg);
				default: o_hrdata <= mft_pkg::UNMAPPED_READ;
			endcase
		end
	end

	// Configuration registers written from the bus.
	always_ff @(posedge i_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mode_control_reg <= '0; // Timer disabled after reset. [RULE16]
			clock_sel_reg <= '0;
			irq_enable_reg <= '0;
		end
		else if (wr)
		begin
			if (wa == mft_pkg::OFS_MODE_CONTROL)
				mode_control_reg <= i_hwdata[mft_pkg::MC_WIDTH-1:0];
			if (wa == mft_pkg::OFS_CLOCK_SEL)
				clock_sel_reg <= i_hwdata[15:0];
			if (wa == mft_pkg::OFS_IRQ_EN)
				irq_enable_reg <= i_hwdata[3:0];
		end
	end

	// ------------------------------------------------------------
	// Clock sources
	// ------------------------------------------------------------
	logic pre_tick; // Prescaled system clock enable.
	logic edge_a, edge_b; // Selected-edge events on pins.
	assign pre_tick = prescale_cnt_reg == 8'h00;

	// Prescaler: one tick every prescale+1 clocks.
	always_ff @(posedge i_clk or negedge rst_b)
	begin
		if (!rst_b)
			prescale_cnt_reg <= 8'h00;
		else if (pre_tick)
			prescale_cnt_reg <= clock_sel_reg[15:8];
		else
			prescale_cnt_reg <= prescale_cnt_reg - 8'h01;
	end

	mft_edge u_edge_a (
		.i_clk(i_clk),
		.i_rst_b(rst_b),
		.i_pin(i_pin_a),
		.i_rising(edge_select_a), // [RULE18]
		.o_event(edge_a)
	);
	mft_edge u_edge_b (
		.i_clk(i_clk),
		.i_rst_b(rst_b),
		.i_pin(i_pin_b),
		.i_rising(edge_select_b), // [RULE18]
		.o_event(edge_b)
	);

	// Tick from a selector; event clocks are barred in capture mode for the first counter.
	function automatic logic sel_tick(input logic [2:0] sel, input logic pre, input logic ev, input logic lvl,
		input logic bar_ext);
		case (sel)
			mft_pkg::CK_SYSTEM: sel_tick = pre;
			mft_pkg::CK_EXT_EVENT: sel_tick = ev && !bar_ext;
			mft_pkg::CK_PULSE_ACC: sel_tick = pre && lvl && !bar_ext;
			default: sel_tick = 1'b0;
		endcase
	endfunction : sel_tick

	logic tick1, tick2, uf1, uf2;
	logic train_start, train_end;
	// First counter runs in PWM, in train only while running, in capture on the prescaled system clock only. [RULE22]
	assign tick1 = sel_tick(ck_first, pre_tick, edge_b, i_pin_b, is_cap) && (is_pwm || is_cap)
		&& (!is_train || train_run_reg); // [RULE23]
	assign tick2 = is_train ? (uf1 && train_run_reg) : (timer_enable_bit && sel_tick(ck_second, pre_tick, edge_b,
		i_pin_b, 1'b0)); // [RULE9] [RULE7]
	assign uf1 = tick1 && first_counter_reg == '0;
	assign uf2 = tick2 && second_counter_reg == '0;
	// Trigger from pin B edge or software bit. [RULE14]
	assign train_start = is_train && !train_run_reg && (train_trigger_source ? sw_trig : edge_b);
	// Train ends when the second counter underflows on a pulse. [RULE10] [RULE13]
	assign train_end = is_train && uf2;

	// Pulse-train run flag.
	always_ff @(posedge i_clk or negedge rst_b)
	begin
		if (!rst_b)
			train_run_reg <= 1'b0;
		else if (!is_train || train_end)
			train_run_reg <= 1'b0; // Clock of the first counter disabled at once. [RULE10]
		else if (train_start)
			train_run_reg <= 1'b1;
	end

	// ------------------------------------------------------------
	// First counter, reload selection and output
	// ------------------------------------------------------------
	logic restart; // Counter stopped or mode left, next reload from A.
	logic cap_a, cap_b;
	assign restart = !is_pwm || ck_first == mft_pkg::CK_NONE || (is_train && !train_run_reg); // [RULE3] [RULE16]
	assign cap_a = is_cap && edge_a; // [RULE17]
	assign cap_b = is_cap && edge_b; // [RULE17]

	// First counter: software load, capture preset, reload or decrement.
	always_ff @(posedge i_clk or negedge rst_b)
	begin
		if (!rst_b)
			first_counter_reg <= '0;
		else if (wr && wa == mft_pkg::OFS_FIRST_CNT)
			first_counter_reg <= i_hwdata[CNT_W-1:0]; // Preloaded start value. [RULE1]
		else if ((cap_a && pin_a_function_enable) || (cap_b && pin_b_function_enable))
			first_counter_reg <= mft_pkg::CNT_ALL_ONES; // Preset after the transfer. [RULE19]
		else if (uf1 && is_pwm)
			first_counter_reg <= next_from_b_reg ? reload_capture_b_reg : reload_capture_a_reg; // [RULE2]
		else if (tick1)
			first_counter_reg <= first_counter_reg - 1'b1; // [RULE1] [RULE23]
	end

	// Alternation between reload registers.
	always_ff @(posedge i_clk or negedge rst_b)
	begin
		if (!rst_b)
			next_from_b_reg <= 1'b0;
		else if (restart)
			next_from_b_reg <= 1'b0; // [RULE3]
		else if (uf1)
			next_from_b_reg <= !next_from_b_reg; // [RULE2]
	end

	// Reload/capture registers: software writes or captured counter.
	always_ff @(posedge i_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			reload_capture_a_reg <= '0;
			reload_capture_b_reg <= '0;
		end
		else
		begin
			if (cap_a)
				reload_capture_a_reg <= first_counter_reg; // [RULE17] [RULE19]
			else if (wr && wa == mft_pkg::OFS_RELOAD_A)
				reload_capture_a_reg <= i_hwdata[CNT_W-1:0];
			if (cap_b)
				reload_capture_b_reg <= first_counter_reg; // [RULE17] [RULE19]
			else if (wr && wa == mft_pkg::OFS_RELOAD_B)
				reload_capture_b_reg <= i_hwdata[CNT_W-1:0];
		end
	end

	// PWM level: follows the initial-level bit while idle, toggles on underflow.
	always_ff @(posedge i_clk or negedge rst_b)
	begin
		if (!rst_b)
			pin_a_out_reg <= 1'b0;
		else if (restart)
			pin_a_out_reg <= pwm_initial_level_bit; // [RULE5]
		else if (uf1)
			pin_a_out_reg <= !pin_a_out_reg; // [RULE4] [RULE9]
	end
	assign o_pin_a = pin_a_out_reg;
	assign o_pin_a_oe_b = !(is_pwm && pin_a_function_enable); // Low while driving.

	// ------------------------------------------------------------
	// Second counter
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge rst_b)
	begin
		if (!rst_b)
			second_counter_reg <= '0;
		else if (wr && wa == mft_pkg::OFS_SECOND_CNT)
			second_counter_reg <= i_hwdata[CNT_W-1:0]; // Rewritten by software before a train. [RULE12]
		else if (uf2 && is_train)
			second_counter_reg <= mft_pkg::CNT_ZERO; // No reload in train mode. [RULE11]
		else if (tick2)
			second_counter_reg <= second_counter_reg - 1'b1; // Wraps to all ones. [RULE7] [RULE23]
	end

	// ------------------------------------------------------------
	// Pending flags and interrupt lines
	// ------------------------------------------------------------
	logic [3:0] set_pend, clr_pend;
	assign set_pend[0] = (uf1 && is_pwm && !next_from_b_reg) || cap_a; // [RULE6] [RULE21]
	assign set_pend[1] = (uf1 && is_pwm && next_from_b_reg) || cap_b; // [RULE6] [RULE21]
	assign set_pend[2] = uf1 && is_cap; // [RULE21]
	assign set_pend[3] = uf2; // [RULE7]
	assign clr_pend = (wr && wa == mft_pkg::OFS_PENDING) ? i_hwdata[3:0] : 4'h0;

	// Sticky flags; a set in the clearing cycle wins.
	always_ff @(posedge i_clk or negedge rst_b)
	begin
		if (!rst_b)
			pending_reg <= 4'h0;
		else
			pending_reg <= (pending_reg & ~clr_pend) | set_pend;
	end
	assign o_irq_a = pending_reg[0] & irq_enable_reg[0]; // [RULE6] [RULE21]
	assign o_irq_b = pending_reg[1] & irq_enable_reg[1]; // [RULE6] [RULE21]
	assign o_irq_c = pending_reg[2] & irq_enable_reg[2]; // [RULE21]
	assign o_irq_d = pending_reg[3] & irq_enable_reg[3]; // [RULE7]

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_reload_from_a: assert property (@(posedge i_clk) disable iff (!rst_b) // [RULE2]
		(uf1 && is_pwm && !next_from_b_reg && !wr) |=> first_counter_reg == $past(reload_capture_a_reg))
		else $error("First counter not reloaded from A.");
	chk_restart_a_first: assert property (@(posedge i_clk) disable iff (!rst_b) // [RULE3]
		restart |=> !next_from_b_reg)
		else $error("Restart did not select reload A.");
	chk_pwm_toggle: assert property (@(posedge i_clk) disable iff (!rst_b) // [RULE4]
		(uf1 && !restart) |=> o_pin_a != $past(o_pin_a))
		else $error("Pin A did not toggle on underflow.");
	chk_idle_level: assert property (@(posedge i_clk) disable iff (!rst_b) // [RULE5]
		(restart && !is_pwm) |=> o_pin_a == $past(pwm_initial_level_bit))
		else $error("PWM level not initial level.");
	chk_pend_a_set: assert property (@(posedge i_clk) disable iff (!rst_b) // [RULE6]
		set_pend[0] |=> pending_reg[0])
		else $error("Pending flag A lost.");
	chk_train_stop: assert property (@(posedge i_clk) disable iff (!rst_b) // [RULE10]
		train_end |=> !train_run_reg ##1 !train_run_reg || $past(train_start))
		else $error("Train did not stop.");
	chk_train_zero: assert property (@(posedge i_clk) disable iff (!rst_b) // [RULE11]
		(train_end && !wr) |=> second_counter_reg == 16'h0000)
		else $error("Second counter not preset to zero.");
	chk_cap_preset: assert property (@(posedge i_clk) disable iff (!rst_b) // [RULE19]
		(cap_a && pin_a_function_enable && !wr) |=> first_counter_reg == 16'hffff
		&& reload_capture_a_reg == $past(first_counter_reg))
		else $error("Capture preset wrong.");
	chk_no_clock_hold: assert property (@(posedge i_clk) disable iff (!rst_b) // [RULE23]
		(ck_first == mft_pkg::CK_NONE && !wr && !cap_a && !cap_b) |=> $stable(first_counter_reg))
		else $error("First counter moved without clock.");
	cov_train_end: cover property (@(posedge i_clk) disable iff (!rst_b) train_end);
	cov_reload_b: cover property (@(posedge i_clk) disable iff (!rst_b) uf1 && next_from_b_reg);
	cov_capture_b: cover property (@(posedge i_clk) disable iff (!rst_b) cap_b);
endmodule : mft_timer
`default_nettype wire

// file: test/dual_timer_pwm_capture_modes_tb.sv
// Self-checking testbench of the multifunction timer over its bus and pins.
`timescale 1ns/10ps
`default_nettype none
module dual_timer_pwm_capture_modes_tb;
	logic clk, rst_b, hsel, hwrite, hready, hresp, pa, pb, pin_a, oe_b;
	logic irq_a, irq_b, irq_c, irq_d;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, q;
	int num_errors, check_count, n;
	// The clock runs at 50 MHz.
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	mft_timer dut (.i_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
		.o_hreadyout(hready), .o_hresp(hresp), .i_pin_a(pa), .i_pin_b(pb), .o_pin_a(pin_a),
		.o_pin_a_oe_b(oe_b), .o_irq_a(irq_a), .o_irq_b(irq_b), .o_irq_c(irq_c), .o_irq_d(irq_d));
	mft_pin_src src (.i_clk(clk), .o_pin_a(pa), .o_pin_b(pb));
	// Prints the counts and the verdict, then ends the run.
	task automatic finish_test;
		$display("Checks %0d, errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test
	// Compares one value and reports a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask : chk
	// One single AHB-Lite transfer; read data lands in q.
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= mft_pkg::HTRANS_NONSEQ;
		k = 0;
		do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 100);
		q = hrdata;
		if (hready !== 1'b1)
		begin
			num_errors++;
			finish_test();
		end
	endtask : xfer
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string m);
		xfer(a, 1'b0, 32'h0);
		chk(q, exp, m);
	endtask : rd_chk
	// Counts cycles to the next change of the pin A output.
	task automatic next_tog(output int c);
		logic l;
		@(negedge clk);
		l = pin_a;
		c = 1;
		while (pin_a === l && c < 200) begin @(negedge clk); c++; end
		if (c >= 200)
		begin
			num_errors++;
			finish_test();
		end
	endtask : next_tog
	// Counts pin A changes over a window of cycles.
	task automatic count_tog(input int cyc, output int c);
		logic l;
		c = 0;
		l = pin_a;
		repeat (cyc) begin @(negedge clk); if (pin_a !== l) c++; l = pin_a; end
	endtask : count_tog
	// PWM run with reloads of 4 and 2, so phases of 5 and 3 cycles.
	task automatic pwm(input logic lvl);
		xfer(mft_pkg::OFS_CLOCK_SEL, 1'b1, 32'h0);
		xfer(mft_pkg::OFS_FIRST_CNT, 1'b1, 32'h3);
		xfer(mft_pkg::OFS_RELOAD_A, 1'b1, 32'h4);
		xfer(mft_pkg::OFS_RELOAD_B, 1'b1, 32'h2);
		xfer(mft_pkg::OFS_MODE_CONTROL, 1'b1, 32'h210 | {28'h0, lvl, 3'h0});
		// The idle level follows the new level bit one edge after the write lands.
		@(posedge clk);
		@(negedge clk);
		chk(32'(oe_b), 32'h0, "pin drive");
		chk(32'(pin_a), 32'(lvl), "initial level");
		xfer(mft_pkg::OFS_CLOCK_SEL, 1'b1, 32'h1);
		next_tog(n);
		chk(32'(pin_a), {31'h0, ~lvl}, "first toggle");
		next_tog(n);
		chk(n, 5, "A phase");
		next_tog(n);
		chk(n, 3, "B phase");
		xfer(mft_pkg::OFS_CLOCK_SEL, 1'b1, 32'h0);
		// Flags A and B set, pin A back at its idle level in bit 6.
		rd_chk(mft_pkg::OFS_PENDING, 32'h3 | {25'h0, lvl, 6'h0}, "pending read");
		chk(q & 32'h3, 32'h3, "reload flags");
		chk(32'(irq_a & irq_b), 32'h1, "reload irq");
		xfer(mft_pkg::OFS_PENDING, 1'b1, 32'hf);
	endtask : pwm
	// Main sequence.
	initial
	begin
		{hsel, hwrite, rst_b} = 3'h0;
		{htrans, hsize, haddr, hwdata} = '0;
		hsize = 3'h2;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		rd_chk(mft_pkg::OFS_MODE_CONTROL, mft_pkg::RESET_WORD, "mode reset");
		chk(32'(hresp), 32'h0, "okay response");
		rd_chk(8'h24, mft_pkg::UNMAPPED_READ, "unmapped");
		xfer(mft_pkg::OFS_IRQ_EN, 1'b1, 32'hf);
		pwm(1'b0);
		pwm(1'b1);
		xfer(mft_pkg::OFS_SECOND_CNT, 1'b1, 32'h3);
		repeat (10) @(posedge clk);
		rd_chk(mft_pkg::OFS_SECOND_CNT, 32'h3, "held count");
		xfer(mft_pkg::OFS_CLOCK_SEL, 1'b1, 32'h8);
		repeat (20) @(posedge clk);
		chk(32'(irq_d), 32'h1, "second underflow");
		xfer(mft_pkg::OFS_CLOCK_SEL, 1'b1, 32'h1);
		xfer(mft_pkg::OFS_FIRST_CNT, 1'b1, 32'h2);
		xfer(mft_pkg::OFS_SECOND_CNT, 1'b1, 32'h2);
		xfer(mft_pkg::OFS_MODE_CONTROL, 1'b1, 32'h314);
		xfer(mft_pkg::OFS_SW_TRIG, 1'b1, 32'h1);
		count_tog(200, n);
		// Three underflow toggles, then the return to the idle level when the train stops.
		chk(n, 4, "software train");
		rd_chk(mft_pkg::OFS_SECOND_CNT, mft_pkg::CNT_ZERO, "train end");
		xfer(mft_pkg::OFS_FIRST_CNT, 1'b1, 32'h2);
		xfer(mft_pkg::OFS_SECOND_CNT, 1'b1, 32'h1);
		xfer(mft_pkg::OFS_MODE_CONTROL, 1'b1, 32'h294);
		count_tog(30, n);
		chk(n, 0, "no trigger");
		fork
			src.drive(1'b1, 1'b1);
			count_tog(200, n);
		join
		chk(n, 2, "pin train");
		src.drive(1'b1, 1'b0);
		xfer(mft_pkg::OFS_CLOCK_SEL, 1'b1, 32'h0);
		xfer(mft_pkg::OFS_PENDING, 1'b1, 32'hf);
		xfer(mft_pkg::OFS_MODE_CONTROL, 1'b1, 32'h251);
		xfer(mft_pkg::OFS_FIRST_CNT, 1'b1, 32'h1234);
		src.drive(1'b0, 1'b1);
		rd_chk(mft_pkg::OFS_RELOAD_A, 32'h1234, "capture A");
		rd_chk(mft_pkg::OFS_FIRST_CNT, 32'(mft_pkg::CNT_ALL_ONES), "preset");
		src.drive(1'b0, 1'b0);
		xfer(mft_pkg::OFS_FIRST_CNT, 1'b1, 32'h42);
		src.drive(1'b1, 1'b1);
		rd_chk(mft_pkg::OFS_RELOAD_B, 32'h2, "wrong edge");
		src.drive(1'b1, 1'b0);
		rd_chk(mft_pkg::OFS_RELOAD_B, 32'h42, "capture B");
		rd_chk(mft_pkg::OFS_FIRST_CNT, 32'h42, "no B preset");
		rd_chk(mft_pkg::OFS_PENDING, 32'h3, "capture pending");
		chk(q & 32'h3, 32'h3, "capture flags");
		chk(32'(irq_a & irq_b), 32'h1, "capture irq");
		xfer(mft_pkg::OFS_CLOCK_SEL, 1'b1, {29'h0, mft_pkg::CK_EXT_EVENT});
		src.drive(1'b1, 1'b1);
		src.drive(1'b1, 1'b0);
		rd_chk(mft_pkg::OFS_FIRST_CNT, 32'h42, "event clock stops");
		// Pulse-accumulate clocking with pin B high must also leave the counter stopped.
		xfer(mft_pkg::OFS_CLOCK_SEL, 1'b1, {29'h0, mft_pkg::CK_PULSE_ACC});
		src.drive(1'b1, 1'b1);
		rd_chk(mft_pkg::OFS_FIRST_CNT, 32'h42, "pulse clock stops");
		// An underflow of the first counter in capture mode raises flag C.
		xfer(mft_pkg::OFS_FIRST_CNT, 1'b1, 32'h1);
		xfer(mft_pkg::OFS_CLOCK_SEL, 1'b1, 32'h1);
		repeat (3) @(negedge clk);
		chk(32'(irq_c), 32'h1, "capture underflow");
		finish_test();
	end
endmodule : dual_timer_pwm_capture_modes_tb
`default_nettype wire

// file: test/mft_pin_src.sv
// Pin source model that drives the two timer input pins.
`timescale 1ns/10ps
`default_nettype none
module mft_pin_src (
	input wire logic i_clk,
	output logic o_pin_a,
	output logic o_pin_b
);
	// Both pins rest low, as behind a pull-down.
	initial
	begin
		o_pin_a = 1'b0;
		o_pin_b = 1'b0;
	end
	// Sets one pin and holds the level three clocks, well past one cycle.
	task automatic drive(input logic sel_b, input logic val);
		@(posedge i_clk);
		if (sel_b)
			o_pin_b <= val;
		else
			o_pin_a <= val;
		repeat (3) @(posedge i_clk);
	endtask : drive
endmodule : mft_pin_src
`default_nettype wire
